//--- hdl/sdil_input_logic.v
// Overview of operation
// R1: Shift one bit on qualified clock/select edge.
// R2: Select and serial clock are interchangeable.
// R3: Load low copies shift register, transparent.
// R4: Clear low forces holding register zero.
// R5: Host returns select high after transfer.
// R6: Host does not shift while load low.
// R7: Data sampled on rising edges, MSB first.
// R8: Load strobe acts without the serial clock.
// R9: Clear acts asynchronously, output minimum scale; here clear passes the pin synchroniser and acts on clk.
// R10: Both registers twelve bits, natural binary.
`include "sdil_defines.vh"

module sdil_input_logic #(
  parameter DATA_W = `SDIL_DATA_W
) (
  input  wire              clk,
  input  wire              nrst,
  input  wire              serial_clk,
  input  wire              select_n,
  input  wire              serial_bit_in,
  input  wire              load_strobe_n,
  input  wire              zero_force_n,
  output reg  [DATA_W-1:0] shift_q,
  output reg  [DATA_W-1:0] hold_q
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  wire sclk_s;
  wire sel_s;
  wire sdi_s;
  wire ld_s;
  wire clr_s;

  sdil_pin_sync #(.RESET_VAL(1'h0)) u_sclk (
    .clk     (clk),
    .nrst    (nrst),
    .pin     (serial_clk),
    .level_q (sclk_s)
  );

  sdil_pin_sync #(.RESET_VAL(1'h1)) u_sel (
    .clk     (clk),
    .nrst    (nrst),
    .pin     (select_n),
    .level_q (sel_s)
  );

  sdil_pin_sync #(.RESET_VAL(1'h0)) u_sdi (
    .clk     (clk),
    .nrst    (nrst),
    .pin     (serial_bit_in),
    .level_q (sdi_s)
  );

  sdil_pin_sync #(.RESET_VAL(1'h1)) u_ld (
    .clk     (clk),
    .nrst    (nrst),
    .pin     (load_strobe_n),
    .level_q (ld_s)
  );

  sdil_pin_sync #(.RESET_VAL(1'h1)) u_clr (
    .clk     (clk),
    .nrst    (nrst),
    .pin     (zero_force_n),
    .level_q (clr_s)
  );

  // --------------------------------------------------------------------------
  // Gated shift clock
  // --------------------------------------------------------------------------
  // The internal shift clock is serial clock OR select; it rises when either
  // input rises while the other sits low, so both inputs act alike.
  reg  gclk_q;
  wire gclk_d;
  wire shift_edge;

  assign gclk_d     = sclk_s | sel_s;   // see R2
  assign shift_edge = gclk_d & ~gclk_q; // see R1

  // The gate starts high, matching idle pins, so reset leaves no false edge.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gclk_q <= 1'h1;
    end else begin
      gclk_q <= gclk_d;
    end
  end

  // --------------------------------------------------------------------------
  // Serial data capture
  // --------------------------------------------------------------------------
  // Data captured one cycle before the edge is used, so a data change that
  // lands with the clock edge cannot slip into the sampled bit.
  reg  data_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_q <= 1'h0;
    end else begin
      data_q <= sdi_s;
    end
  end

  // --------------------------------------------------------------------------
  // Input shift register
  // --------------------------------------------------------------------------
  reg  [DATA_W-1:0] shift_d;

  always @* begin
    shift_d = shift_q;
    if (shift_edge) begin
      shift_d = {shift_q[DATA_W-2:0], data_q}; // see R7
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_q <= `SDIL_ZERO_CODE; // see R10
    end else begin
      shift_q <= shift_d;
    end
  end

  // --------------------------------------------------------------------------
  // Strobe edge tracking
  // --------------------------------------------------------------------------
  // Both trackers reset to the idle high level of their strobes, so the
  // release of reset is never taken for a strobe edge.
  reg  ld_q;
  reg  clr_q;
  wire ld_fall;
  wire clr_rise;

  assign ld_fall  = ld_q & ~ld_s;   // see R3
  assign clr_rise = clr_s & ~clr_q; // see R4

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ld_q  <= 1'h1;
      clr_q <= 1'h1;
    end else begin
      ld_q  <= ld_s;
      clr_q <= clr_s;
    end
  end

  // --------------------------------------------------------------------------
  // Holding register control
  // --------------------------------------------------------------------------
  // Clear has priority over load in every state.
  localparam ST_LATCH  = 2'h0; // Keeps its value while load is high.
  localparam ST_COPY   = 2'h1; // Takes the shift register on a load fall.
  localparam ST_FOLLOW = 2'h2; // Transparent while load stays low.
  localparam ST_ZERO   = 2'h3; // Forced to zero while clear is low.

  reg  [1:0] state_q;
  reg  [1:0] state_d;

  always @* begin
    state_d = state_q;
    if (!clr_s) begin
      state_d = ST_ZERO; // see R4 see R9
    end else begin
      case (state_q)
        ST_LATCH: begin
          if (ld_fall) begin
            state_d = ST_COPY; // see R3 see R8
          end else if (!ld_s) begin
            state_d = ST_FOLLOW;
          end
        end
        ST_COPY: begin
          if (ld_s) begin
            state_d = ST_LATCH;
          end else begin
            state_d = ST_FOLLOW;
          end
        end
        ST_FOLLOW: begin
          if (ld_s) begin
            state_d = ST_LATCH;
          end
        end
        ST_ZERO: begin
          if (clr_rise && ld_s) begin
            state_d = ST_LATCH; // see R4
          end else if (clr_rise) begin
            state_d = ST_FOLLOW;
          end
        end
        default: begin
          state_d = ST_LATCH;
        end
      endcase
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_LATCH;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // Holding register
  // --------------------------------------------------------------------------
  reg  [DATA_W-1:0] hold_d;

  always @* begin
    case (state_d)
      ST_ZERO: begin
        hold_d = `SDIL_ZERO_CODE; // see R9
      end
      ST_COPY, ST_FOLLOW: begin
        hold_d = shift_q; // see R3
      end
      default: begin
        hold_d = hold_q;
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= `SDIL_ZERO_CODE;
    end else begin
      hold_q <= hold_d;
    end
  end

endmodule

//--- hdl/sdil_defines.vh
`ifndef SDIL_DEFINES_VH
`define SDIL_DEFINES_VH

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define SDIL_DATA_W     12
`define SDIL_ZERO_CODE  12'h000
`define SDIL_SYNC_W     3

`endif

//--- hdl/sdil_pin_sync.v
// ----------------------------------------------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------------------------------------------
// A change is accepted only when the second and third stages agree, so the
// first stage feeds nothing but the second.
module sdil_pin_sync #(
  parameter RESET_VAL = 1'h1
) (
  input  wire clk,
  input  wire nrst,
  input  wire pin,
  output reg  level_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q    <= RESET_VAL;
      s2_q    <= RESET_VAL;
      s3_q    <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule

//--- dv/sdil_monitor.sv
module sdil_monitor #(
  parameter DATA_W = 12
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              serial_clk,
  input wire logic              select_n,
  input wire logic              serial_bit_in,
  input wire logic              load_strobe_n,
  input wire logic              zero_force_n,
  input wire logic [DATA_W-1:0] shift_q,
  input wire logic [DATA_W-1:0] hold_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  localparam logic [DATA_W-1:0] LOW_MASK = {1'b0, {(DATA_W-1){1'b1}}};
  sequence clr_done;
    !zero_force_n [*6] ##1 (zero_force_n && load_strobe_n);
  endsequence
  a_quiet_keeps:
    assert property ($stable({serial_clk, select_n}) [*7] |-> $stable(shift_q)) else $error("shift");
  a_msb_first:
    assert property (shift_q != $past(shift_q) |-> (shift_q >> 1) == ($past(shift_q) & LOW_MASK))
    else $error("order");
  a_clear_zero:
    assert property (!zero_force_n [*6] |-> hold_q == '0) else $error("clear");
  a_clear_stays:
    assert property (clr_done |-> (hold_q == '0) [*3]) else $error("zeros");
  a_hold_keep:
    assert property ((load_strobe_n && zero_force_n) [*6] |-> $stable(hold_q)) else $error("keep");
  a_load_copy:
    assert property ((!load_strobe_n && zero_force_n) [*8] |-> hold_q == shift_q) else $error("load");
endmodule
bind sdil_input_logic sdil_monitor #(
  .DATA_W (DATA_W)
) u_mon (
  .clk           (clk),
  .nrst          (nrst),
  .serial_clk    (serial_clk),
  .select_n      (select_n),
  .serial_bit_in (serial_bit_in),
  .load_strobe_n (load_strobe_n),
  .zero_force_n  (zero_force_n),
  .shift_q       (shift_q),
  .hold_q        (hold_q)
);

//--- dv/sdil_host.sv
module sdil_host (
  input  wire logic clk,
  output logic      sck,
  output logic      sel_n,
  output logic      dat
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {sck, sel_n, dat} = 3'h2;
  task automatic send(input logic [11:0] w, input bit g);
    for (int i = 11; i >= 0; i--) begin
      {sck, sel_n, dat} <= {2'h0, w[i]};
      repeat (4) @(posedge clk);
      if (g) begin
        sel_n <= 1'h1;
      end else begin
        sck <= 1'h1;
      end
      repeat (4) @(posedge clk);
    end
    sel_n <= 1'h1;
    dat   <= ~w[0];
  endtask
  // Toggles the serial clock and data with select held high.
  task automatic idle_clk(input int n);
    for (int i = 0; i < n; i++) begin
      {sck, dat} <= {~sck, ~dat};
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

//--- dv/sdil_input_logic_tb.sv
module sdil_input_logic_tb;
  timeunit 1ns; timeprecision 1ns;
  logic        clk, nrst, sck, sel_n, dat, ld_n, clr_n;
  logic [11:0] sh, hd;
  int          n_errors, n_checks, cyc;
  sdil_host host (.clk(clk), .sck(sck), .sel_n(sel_n), .dat(dat));
  sdil_input_logic dut (.clk(clk), .nrst(nrst), .serial_clk(sck), .select_n(sel_n),
    .serial_bit_in(dat), .load_strobe_n(ld_n), .zero_force_n(clr_n), .shift_q(sh), .hold_q(hd));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 8000) begin
    n_errors++;
    results;
  end
  task chk(input string nm, input logic [11:0] e, s);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task t_shift(input logic [11:0] w, h, input bit g);
    host.send(w, g);
    repeat (8) @(posedge clk);
    chk("shift", w, sh);
    chk("keep", h, hd);
    $display("shift mode %0d done", g);
  endtask
  task t_load(input logic [11:0] w);
    ld_n <= 0;
    repeat (8) @(posedge clk);
    chk("load", w, hd);
    ld_n <= 1;
    repeat (8) @(posedge clk);
    $display("load done");
  endtask
  task t_clear;
    {ld_n, clr_n} <= 2'b00;
    repeat (8) @(posedge clk);
    chk("clear", 12'h000, hd);
    ld_n <= 1;
    repeat (8) @(posedge clk);
    clr_n <= 1;
    repeat (8) @(posedge clk);
    chk("zeros", 12'h000, hd);
    $display("clear done");
  endtask
  task t_idle(input logic [11:0] w, h);
    host.idle_clk(6);
    repeat (8) @(posedge clk);
    chk("idle shift", w, sh);
    chk("idle hold", h, hd);
    $display("idle clock done");
  endtask
  task t_reset(input logic [11:0] h);
    chk("pre reset", h, hd);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    chk("reset shift", 12'h000, sh);
    chk("reset hold", 12'h000, hd);
    @(posedge clk);
    chk("reset hold", 12'h000, hd);
    $display("reset done");
  endtask
  initial begin
    nrst     = 1'h0;
    ld_n     = 1'h1;
    clr_n    = 1'h1;
    cyc      = 0;
    n_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    chk("reset", 12'h000, hd);
    chk("reset shift", 12'h000, sh);
    t_shift(12'hfff, 12'h000, 1'h0);
    t_shift(12'h5a3, 12'h000, 1'h1);
    t_idle(12'h5a3, 12'h000);
    t_load(12'h5a3);
    t_shift(12'h0c6, 12'h5a3, 1'h0);
    t_clear;
    t_load(12'h0c6);
    t_reset(12'h0c6);
    t_shift(12'h93e, 12'h000, 1'h1);
    results;
  end
endmodule
